// ### verilog/twd_debug_regs.sv
// Two-wire debug link and its register front end
// What this block does
// (R1) Host clocks the link; registers reached only over clock and data pins.
// (R2) Eight-bit address select register, reset zero, picks data register.
// (R3) Select 0x00: data read returns part identification.
// (R4) Select 0x01: data read returns silicon revision.
// (R5) Select 0x02: data read and write reach programming control.
// (R6) Select 0xB4: data read and write reach programming data.
// (R7) Part identification is a fixed read-only code; writes ignored.
// (R8) Silicon revision comes from the part, not a fixed constant.
// (R9) Programming enables after writes 0x02 then 0x01; only reset clears.
// (R10) Programming data carries commands 0x06, 0x07, 0x08, 0x03.
// (R11) Unassigned select reads zero; writes there are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "twd_params.svh"

module twd_debug_regs #(
    parameter logic [7:0] PART_IDENT = 8'h5c, // Arbitrary value
    parameter int IDLE_CYC = `TWD_IDLE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic debug_clock_pin,
    input wire logic debug_data_pin_in,
    output logic debug_data_pin_out,
    output logic debug_data_pin_oe,
    input wire logic [7:0] silicon_revision_strap,
    input wire logic [7:0] flash_data_rd,
    input wire logic flash_cmd_expect,
    output logic flash_prog_enable,
    output logic flash_data_wr_stb,
    output logic flash_data_rd_stb,
    output logic [7:0] flash_data_wr,
    output logic flash_cmd_stb
);
    import twd_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic ck_s1_q, ck_s2_q, ck_s3_q, d_s1_q, d_s2_q;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {ck_s1_q, ck_s2_q, ck_s3_q} <= 3'h0;
            {d_s1_q, d_s2_q} <= 2'h0;
        end
        else
        begin
            {ck_s1_q, ck_s2_q, ck_s3_q} <= {debug_clock_pin, ck_s1_q, ck_s2_q};
            {d_s1_q, d_s2_q} <= {debug_data_pin_in, d_s1_q};
        end
    end
    wire ck_rise = ck_s2_q && !ck_s3_q; // R1
    wire ck_fall = !ck_s2_q && ck_s3_q;

    // ------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------
    // A long low clock realigns the frame, so a lost edge cannot hang it
    logic [15:0] idle_q;
    twd_state_e state_q, state_d;
    logic [1:0] ins_q;
    logic [7:0] sh_q, sh_d;
    logic [3:0] cnt_q, cnt_d;
    logic drive_q;
    logic [7:0] addr_q, ctl_q, rev_q;
    logic rev_taken_q, armed_q, prog_q;

    // Gated by the clock level so the first rise after idle is not lost
    wire idle_hit = !ck_s2_q && (idle_q >= 16'(IDLE_CYC));
    wire ins_done = ck_rise && state_q == TWD_ST_INS && cnt_q == 4'h1;
    wire [1:0] ins_now = {d_s2_q, sh_q[7]};
    wire wr_done = ck_rise && state_q == TWD_ST_WDATA && cnt_q == 4'h7;
    wire [7:0] wr_byte = {d_s2_q, sh_q[7:1]};
    wire rd_load = ins_done && ins_now == `TWD_INS_DATA_RD;
    wire ar_load = ins_done && ins_now == `TWD_INS_ADDR_RD;
    wire rd_done = ck_rise && state_q == TWD_ST_RDATA && cnt_q == 4'h7;

    // ------------------------------------------------------------
    // Register selection
    // ------------------------------------------------------------
    wire sel_ident = addr_q == `TWD_SEL_IDENT;
    wire sel_rev = addr_q == `TWD_SEL_REV;
    wire sel_ctl = addr_q == `TWD_SEL_CTL;
    wire sel_data = addr_q == `TWD_SEL_DATA;
    wire [7:0] rd_mux = sel_ident ? PART_IDENT : // R3 R7
        sel_rev ? rev_q : // R4
        sel_ctl ? ctl_q : // R5
        sel_data ? flash_data_rd : // R6
        8'h00; // R11
    wire addr_wr = wr_done && ins_q == `TWD_INS_ADDR_WR;
    wire data_wr = wr_done && ins_q == `TWD_INS_DATA_WR;
    wire ctl_wr = data_wr && sel_ctl; // R5
    wire fpd_wr = data_wr && sel_data; // R6
    wire cmd_code = wr_byte == `TWD_CMD_BLK_RD ||
        wr_byte == `TWD_CMD_BLK_WR || wr_byte == `TWD_CMD_PG_ERASE ||
        wr_byte == `TWD_CMD_DEV_ERASE;

    always_comb
    begin
        state_d = state_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        if (idle_hit)
        begin
            state_d = TWD_ST_INS;
            cnt_d = 4'h0;
        end
        else if (ck_rise)
        begin
            sh_d = {d_s2_q, sh_q[7:1]};
            cnt_d = cnt_q + 4'h1;
            case (state_q)
                TWD_ST_INS:
                begin
                    if (cnt_q == 4'h1)
                    begin
                        cnt_d = 4'h0;
                        if (rd_load)
                        begin
                            state_d = TWD_ST_RDATA;
                            sh_d = rd_mux;
                        end
                        else if (ar_load)
                        begin
                            state_d = TWD_ST_RDATA;
                            sh_d = addr_q; // R2
                        end
                        else
                            state_d = TWD_ST_WDATA;
                    end
                end
                TWD_ST_WDATA:
                begin
                    if (cnt_q == 4'h7)
                    begin
                        state_d = TWD_ST_INS;
                        cnt_d = 4'h0;
                    end
                end
                TWD_ST_RDATA:
                begin
                    sh_d = sh_q;
                    if (cnt_q == 4'h7)
                    begin
                        state_d = TWD_ST_INS;
                        cnt_d = 4'h0;
                    end
                end
                default:
                    state_d = TWD_ST_INS;
            endcase
        end
        else if (ck_fall && state_q == TWD_ST_RDATA && drive_q)
            sh_d = {1'b0, sh_q[7:1]};
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= TWD_ST_INS;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            ins_q <= 2'h0;
            idle_q <= 16'h0000;
            drive_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            if (ins_done)
                ins_q <= ins_now;
            idle_q <= ck_s2_q ? 16'h0000 : (idle_hit ? idle_q : idle_q + 16'h1);
            if (state_d != TWD_ST_RDATA)
                drive_q <= 1'b0;
            else if (ck_fall)
                drive_q <= 1'b1; // R1
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_q <= `TWD_ADDR_RST;
            ctl_q <= `TWD_CTL_RST;
            rev_q <= 8'h00;
            rev_taken_q <= 1'b0;
            armed_q <= 1'b0;
            prog_q <= 1'b0;
        end
        else
        begin
            if (addr_wr)
                addr_q <= wr_byte; // R2
            // Strap caught after release, never under the reset itself
            if (!rev_taken_q)
            begin
                rev_q <= silicon_revision_strap; // R8
                rev_taken_q <= 1'b1;
            end
            if (ctl_wr)
            begin
                ctl_q <= wr_byte; // R5
                armed_q <= wr_byte == `TWD_UNLOCK_1; // R9
                if (armed_q && wr_byte == `TWD_UNLOCK_2)
                    prog_q <= 1'b1; // R9
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flash_data_wr <= 8'h00;
            flash_data_wr_stb <= 1'b0;
            flash_data_rd_stb <= 1'b0;
            flash_cmd_stb <= 1'b0;
        end
        else
        begin
            flash_data_wr_stb <= fpd_wr && prog_q; // R6
            flash_data_rd_stb <= rd_load && sel_data && prog_q;
            flash_cmd_stb <= fpd_wr && prog_q && flash_cmd_expect &&
                cmd_code; // R10
            if (fpd_wr)
                flash_data_wr <= wr_byte;
        end
    end

    assign flash_prog_enable = prog_q;
    assign debug_data_pin_oe = drive_q && state_q == TWD_ST_RDATA;
    assign debug_data_pin_out = sh_q[0];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    addr_write_a: assert property (addr_wr |=> addr_q == $past(wr_byte)) // R2
        else $error("address select not loaded");
    ident_read_a: assert property (rd_load && sel_ident |=> // R3
        sh_q == PART_IDENT) else $error("part ident not returned");
    rev_read_a: assert property (rd_load && sel_rev |=> sh_q == rev_q) // R4
        else $error("revision not returned");
    ctl_read_a: assert property (rd_load && sel_ctl |=> sh_q == ctl_q) // R5
        else $error("control not returned");
    data_write_a: assert property (fpd_wr && prog_q |=> // R6
        flash_data_wr_stb && flash_data_wr == $past(wr_byte))
        else $error("programming data write lost");
    unmapped_read_a: assert property (rd_load && !sel_ident && !sel_rev &&
        !sel_ctl && !sel_data |=> sh_q == 8'h00) // R11
        else $error("unassigned read not zero");
    prog_sticky_a: assert property (prog_q |=> prog_q) // R9
        else $error("programming enable dropped");
    prog_unlock_a: assert property ($rose(prog_q) |-> // R9
        $past(ctl_wr && armed_q && wr_byte == `TWD_UNLOCK_2))
        else $error("programming enabled out of order");
    cmd_code_a: assert property (flash_cmd_stb |-> // R10
        flash_data_wr inside {`TWD_CMD_BLK_RD, `TWD_CMD_BLK_WR,
        `TWD_CMD_PG_ERASE, `TWD_CMD_DEV_ERASE})
        else $error("bad command strobed");
    drive_read_a: assert property (debug_data_pin_oe |-> // R1
        ins_q[0] == ins_q[1]) else $error("data pin driven outside read");
    ident_fixed_a: assert property (data_wr && !sel_ctl && !sel_data |=> // R7
        $stable(ctl_q) && $stable(addr_q) && !flash_data_wr_stb)
        else $error("ignored write had an effect");
endmodule // twd_debug_regs

`default_nettype wire

// ### verilog/twd_params.svh
// Constants of the two-wire debug register front end
`ifndef TWD_PARAMS_SVH
`define TWD_PARAMS_SVH

// Data register selections
`define TWD_SEL_IDENT 8'h00
`define TWD_SEL_REV 8'h01
`define TWD_SEL_CTL 8'h02
`define TWD_SEL_DATA 8'hb4
`define TWD_ADDR_RST 8'h00
`define TWD_CTL_RST 8'h00

// Programming unlock sequence
`define TWD_UNLOCK_1 8'h02
`define TWD_UNLOCK_2 8'h01

// Flash command codes
`define TWD_CMD_BLK_RD 8'h06
`define TWD_CMD_BLK_WR 8'h07
`define TWD_CMD_PG_ERASE 8'h08
`define TWD_CMD_DEV_ERASE 8'h03

// Link instruction codes, sent LSB first
`define TWD_INS_DATA_RD 2'h0
`define TWD_INS_ADDR_WR 2'h1
`define TWD_INS_DATA_WR 2'h2
`define TWD_INS_ADDR_RD 2'h3

// Timing
`define TWD_CLK_NS 10
`define TWD_IDLE_NS 2000
`define TWD_IDLE_CYC ((`TWD_IDLE_NS + `TWD_CLK_NS - 1) / `TWD_CLK_NS)

`endif

// ### verilog/twd_pkg.sv
// Types of the two-wire debug register front end
package twd_pkg;
    typedef enum logic [2:0] {
        TWD_ST_INS = 3'h1,
        TWD_ST_WDATA = 3'h2,
        TWD_ST_RDATA = 3'h4
    } twd_state_e;
endpackage

// ### verilog/dummy_unused_never.sv
// Holds no logic; the whole block lives in twd_debug_regs.sv

// ### tb/twd_host_model.sv
// Host side model of the two-wire debug link
`timescale 1ns/1ps
`default_nettype none

module twd_host_model (
    input wire logic ref_clk,
    input wire logic dev_out,
    input wire logic dev_oe,
    output logic debug_clock_pin,
    output logic debug_data_pin
);
    logic drv_en = 1'b0;
    logic drv_bit = 1'b0;
    logic junk = 1'b0;

    // ----------------------------------------
    // Wire level
    // ----------------------------------------
    // Released line toggles so a stale bit cannot pass as read data
    always @(posedge ref_clk) junk <= ~junk;
    assign debug_data_pin = dev_oe ? dev_out : (drv_en ? drv_bit : junk);

    initial debug_clock_pin = 1'b0;

    // ----------------------------------------
    // Frame: two instruction bits, eight data bits, LSB first
    // ----------------------------------------
    // Clock rests low between frames and only runs inside them
    task automatic frame(input logic [1:0] ins, input logic [7:0] wd,
                         output logic [7:0] rd);
        logic rdir;
        rdir = (ins[0] == ins[1]);
        for (int i = 0; i < 10; i++)
        begin
            drv_en = !(rdir && i > 1);
            drv_bit = (i < 2) ? ins[i] : wd[i-2];
            #80 debug_clock_pin = 1'b1;
            if (i > 1) rd[i-2] = debug_data_pin;
            #80 debug_clock_pin = 1'b0;
        end
        drv_en = 1'b0;
        // Rest low so the next frame never drives in this time step
        #80;
    endtask

    // Lone clock pulse: a cut frame the device must drop on idle
    task automatic pulse;
        drv_en = 1'b1;
        drv_bit = 1'b1;
        #80 debug_clock_pin = 1'b1;
        #80 debug_clock_pin = 1'b0;
        drv_en = 1'b0;
    endtask
endmodule // twd_host_model

`default_nettype wire

// ### tb/tb.sv
// Self-checking bench of the two-wire debug register front end
`timescale 1ns/1ps
`default_nettype none
`include "twd_params.svh"

module tb;
    localparam logic [7:0] IDENT = 8'h5c; // Arbitrary value
    localparam logic [7:0] REV = 8'h37; // Arbitrary value
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] strap = REV;
    logic [7:0] fl_rd = 8'h00;
    logic cmd_expect = 1'b0;
    logic clk_pin, data_pin, d_out, d_oe, en, wr_stb, rd_stb, cmd_stb;
    logic [7:0] wr_byte, rb;
    int n_fail = 0;
    int comparisons = 0;
    int n_wr = 0, n_rd = 0, n_cmd = 0, cyc = 0;

    always #5 ref_clk = ~ref_clk;

    twd_debug_regs #(.PART_IDENT(IDENT), .IDLE_CYC(50)) twd_debug_regs_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .debug_clock_pin(clk_pin),
        .debug_data_pin_in(data_pin), .debug_data_pin_out(d_out),
        .debug_data_pin_oe(d_oe), .silicon_revision_strap(strap),
        .flash_data_rd(fl_rd), .flash_cmd_expect(cmd_expect),
        .flash_prog_enable(en), .flash_data_wr_stb(wr_stb),
        .flash_data_rd_stb(rd_stb), .flash_data_wr(wr_byte),
        .flash_cmd_stb(cmd_stb));

    twd_host_model twd_host_model_i (
        .ref_clk(ref_clk), .dev_out(d_out), .dev_oe(d_oe),
        .debug_clock_pin(clk_pin), .debug_data_pin(data_pin));

    // ----------------------------------------
    // Strobe counters and hang guard
    // ----------------------------------------
    always @(posedge ref_clk)
    begin
        cyc++;
        if (wr_stb === 1'b1) n_wr++;
        if (rd_stb === 1'b1) n_rd++;
        if (cmd_stb === 1'b1) n_cmd++;
        if (cyc == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic check8(input string what, input logic [7:0] exp, got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic op(input logic [1:0] ins, input logic [7:0] wd);
        twd_host_model_i.frame(ins, wd, rb);
    endtask

    task automatic give_verdict;
        $display("Checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        op(`TWD_INS_ADDR_RD, 8'h00);
        check8("addr reset", 8'h00, rb);
        op(`TWD_INS_DATA_RD, 8'h00);
        check8("ident", IDENT, rb);
        op(`TWD_INS_DATA_WR, 8'hff);
        op(`TWD_INS_DATA_RD, 8'h00);
        check8("ident rewritten", IDENT, rb);
        op(`TWD_INS_ADDR_WR, `TWD_SEL_REV);
        op(`TWD_INS_DATA_RD, 8'h00);
        check8("revision", REV, rb);
        op(`TWD_INS_ADDR_WR, 8'h77);
        op(`TWD_INS_ADDR_RD, 8'h00);
        check8("addr", 8'h77, rb);
        op(`TWD_INS_DATA_WR, 8'h12);
        op(`TWD_INS_DATA_RD, 8'h00);
        check8("unassigned", 8'h00, rb);
        $display("Test regs done");
    endtask

    task automatic t_unlock;
        op(`TWD_INS_ADDR_WR, `TWD_SEL_DATA);
        op(`TWD_INS_DATA_WR, `TWD_CMD_BLK_WR);
        check8("locked strobes", 8'h00, n_wr[7:0]);
        op(`TWD_INS_ADDR_WR, `TWD_SEL_CTL);
        op(`TWD_INS_DATA_WR, `TWD_UNLOCK_2);
        op(`TWD_INS_DATA_WR, `TWD_UNLOCK_2);
        check8("early enable", 8'h00, {7'h0, en});
        op(`TWD_INS_DATA_WR, `TWD_UNLOCK_1);
        op(`TWD_INS_DATA_WR, `TWD_UNLOCK_2);
        check8("enable", 8'h01, {7'h0, en});
        op(`TWD_INS_DATA_RD, 8'h00);
        check8("control", `TWD_UNLOCK_2, rb);
        $display("Test unlock done");
    endtask

    task automatic t_data;
        logic [7:0] cmds [4];
        int c0;
        cmds = '{`TWD_CMD_BLK_RD, `TWD_CMD_BLK_WR, `TWD_CMD_PG_ERASE,
                 `TWD_CMD_DEV_ERASE};
        cmd_expect = 1'b1;
        fl_rd = 8'ha6;
        op(`TWD_INS_ADDR_WR, `TWD_SEL_DATA);
        foreach (cmds[k])
        begin
            c0 = n_cmd;
            op(`TWD_INS_DATA_WR, cmds[k]);
            check8("data byte", cmds[k], wr_byte);
            check8("command strobes", c0[7:0] + 8'h1, n_cmd[7:0]);
        end
        op(`TWD_INS_DATA_WR, 8'h55);
        check8("non command", 8'h04, n_cmd[7:0]);
        check8("write strobes", 8'h05, n_wr[7:0]);
        cmd_expect = 1'b0;
        op(`TWD_INS_DATA_WR, `TWD_CMD_BLK_RD);
        check8("unexpected command", 8'h04, n_cmd[7:0]);
        check8("write strobes idle", 8'h06, n_wr[7:0]);
        op(`TWD_INS_DATA_RD, 8'h00);
        check8("data read", 8'ha6, rb);
        check8("read strobes", 8'h01, n_rd[7:0]);
        $display("Test data done");
    endtask

    // Strap changes across a reset, so revision is not a constant
    task automatic t_rerst;
        strap = 8'h3a;
        rst_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        check8("enable after reset", 8'h00, {7'h0, en});
        op(`TWD_INS_ADDR_RD, 8'h00);
        check8("addr after reset", 8'h00, rb);
        op(`TWD_INS_ADDR_WR, `TWD_SEL_REV);
        op(`TWD_INS_DATA_RD, 8'h00);
        check8("new revision", 8'h3a, rb);
        $display("Test reset done");
    endtask

    // A cut frame is dropped after a long low clock
    task automatic t_idle;
        twd_host_model_i.pulse();
        repeat (80) @(posedge ref_clk);
        #1;
        op(`TWD_INS_ADDR_RD, 8'h00);
        check8("addr after idle", `TWD_SEL_REV, rb);
        $display("Test idle done");
    endtask

    initial
    begin
        repeat (20) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        t_regs();
        t_unlock();
        t_data();
        t_rerst();
        t_idle();
        give_verdict();
    end
endmodule // tb

`default_nettype wire
